// file: adc_port_pkg.sv
// Package with constants and carrier types of the byte-wide converter host port
// Summary of operation
// R1: Bus cycles only while select is low
// R2: Upper byte on low eight lines when high
// R3: Low byte captured from low lines
// R4: Read with select low drives twelve bits
// R5: Host reads calibration register in two cycles
// R6: Host loads registers by two byte writes
// R7: Lines zero to eight bidirectional three-state
// R8: Lines nine to eleven output only
// R9: Unipolar straight binary, bipolar twos complement
// R10: All timing derived from master clock
// R11: Busy rises on trigger fall until done
// R12: Busy also high during calibration
// R13: Write only with write strobe and select
// R14: Read only with read strobe and select
// R15: Host writes low byte then high byte
// R16: Host reads calibration low byte first
// R17: Drive data only during selected read
// R18: Board pulls upper lines high on narrow bus
package adc_port_pkg;
    localparam int DATA_W        = 12;   // Result width
    localparam int BYTE_W        = 8;    // Bus byte width
    localparam int LOW_PINS      = 9;    // Bidirectional lines
    localparam int UP_PINS       = 3;    // Output-only lines
    localparam int WORD_W        = 16;   // Register word width
    localparam int CONV_CYCLES   = 14;   // Master clock periods per conversion
    localparam int CAL_CYCLES    = 256;  // Master clock periods per calibration
    localparam int FIFO_DEPTH    = 32;   // Result buffer depth
    localparam int ADDR_MSB      = 15;   // Address field top bit
    localparam int ADDR_LSB      = 14;   // Address field low bit
    localparam logic [1:0] ADDR_CTRL = 2'h3; // Control register address
    localparam logic [1:0] ADDR_CAL  = 2'h2; // Calibration register address
    localparam logic [1:0] ADDR_TEST = 2'h1; // Test register address
    localparam int CTRL_BIPOLAR  = 0;    // Control: bipolar coding
    localparam int CTRL_CAL      = 1;    // Control: start calibration
    localparam int CTRL_RDSEL    = 6;    // Control: read select low bit
    localparam logic [13:0] CTRL_RESET = 14'h0000; // Control reset value
    localparam logic [1:0] RSEL_DATA = 2'h0; // Read select: result
    localparam logic [1:0] RSEL_CTRL = 2'h1; // Read select: control
    localparam logic [1:0] RSEL_CAL  = 2'h2; // Read select: calibration
    // Sample and its coding mode travel together
    typedef struct packed {
        logic                bipolar;
        logic [DATA_W-1:0]   code;
    } sample_t;
    // Engine states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_CAL  = 3'b100
    } eng_state_t;
endpackage

// file: sample_fifo.sv
// Result buffer with valid/ready on both sides
`timescale 1ns/1ns
module sample_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];   // Flip-flop storage
    logic [AW-1:0]    wrPtr_q;         // Write index
    logic [AW-1:0]    rdPtr_q;         // Read index
    logic [AW:0]      count_q;         // Fill level
    logic             push;
    logic             pop;
    assign inReady  = (count_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign outValid = (count_q != '0);
    assign outData  = mem_q[rdPtr_q];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end
    // Pointers and level
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// file: adc_byte_parallel_host_port.sv
// Byte-wide host port: register writes, result reads, busy sequencing
`timescale 1ns/1ns
module adc_byte_parallel_host_port
    import adc_port_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES,  // Conversion length in master clocks
    parameter int CAL_LEN  = CAL_CYCLES,   // Calibration length in master clocks
    parameter int DEPTH    = FIFO_DEPTH    // Result buffer depth
) (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic                chipSelN,
    input  wire logic                readN,
    input  wire logic                writeN,
    input  wire logic                upper_byte_select,
    input  wire logic                master_clock_in,
    input  wire logic                convert_trigger,
    input  wire logic [DATA_W-1:0]   sampleCode,
    input  wire logic [LOW_PINS-1:0] data_bus_bidir_in,
    output logic [LOW_PINS-1:0]      data_bus_bidir_out,
    output logic [LOW_PINS-1:0]      data_bus_bidir_oe,
    output logic [UP_PINS-1:0]       data_bus_upper_out,
    output logic [UP_PINS-1:0]       data_bus_upper_oe,
    output logic                     busy,
    output logic                     fifoFull
);
    ////////////////////////////////////////////////////////////////////////
    // Strobe edge detection (pins taken as synchronous)
    logic       wrN_q;            // Last write strobe
    logic       rdN_q;            // Last read strobe
    logic       mclk_q;           // Last master clock level
    logic       trig_q;           // Last trigger level
    logic       wrEnd;            // Write strobe rising while selected
    logic       rdEnd;            // Read strobe rising while selected
    logic       mclkTick;         // Master clock rising edge
    logic       trigFall;         // Trigger falling edge
    logic       rdActive;         // Selected read in progress
    always_ff @(posedge clk) begin
        if (srst) begin
            wrN_q  <= 1'b1;
            rdN_q  <= 1'b1;
            mclk_q <= 1'b0;
            trig_q <= 1'b1;
        end else begin
            wrN_q  <= writeN | chipSelN;       // see R1
            rdN_q  <= readN | chipSelN;        // see R1
            mclk_q <= master_clock_in;
            trig_q <= convert_trigger;
        end
    end
    assign wrEnd    = !wrN_q && (writeN | chipSelN);   // see R13
    assign rdEnd    = !rdN_q && (readN | chipSelN);    // see R14
    assign rdActive = !readN && !chipSelN;             // see R14
    assign mclkTick = master_clock_in && !mclk_q;      // see R10
    assign trigFall = trig_q && !convert_trigger;      // see R11

    ////////////////////////////////////////////////////////////////////////
    // Two-byte register write assembly
    logic [BYTE_W-1:0] lowByte_q;   // Captured low byte
    logic              lowHeld_q;   // Low byte waiting for high byte
    logic [13:0]       ctrl_q;      // Control register
    logic [13:0]       cal_q;       // Calibration register
    logic [13:0]       test_q;      // Test register
    logic [WORD_W-1:0] word;        // Assembled word
    logic              calReq;      // Calibration requested by write
    assign word   = {data_bus_bidir_in[BYTE_W-1:0], lowByte_q};
    assign calReq = wrEnd && upper_byte_select && lowHeld_q
                    && word[ADDR_MSB:ADDR_LSB] == ADDR_CTRL && word[CTRL_CAL];
    always_ff @(posedge clk) begin
        if (srst) begin
            lowByte_q <= 8'h00;
            lowHeld_q <= 1'b0;
            ctrl_q    <= CTRL_RESET;
            cal_q     <= 14'h0000;
            test_q    <= 14'h0000;
        end else if (wrEnd) begin
            if (!upper_byte_select) begin
                // Low byte only latched; no register changes yet
                lowByte_q <= data_bus_bidir_in[BYTE_W-1:0];    // see R3, R6
                lowHeld_q <= 1'b1;                              // see R15
            end else if (lowHeld_q) begin
                // High byte completes the word; lines 8..11 never sampled
                lowHeld_q <= 1'b0;                              // see R2, R8
                unique case (word[ADDR_MSB:ADDR_LSB])
                    ADDR_CTRL: ctrl_q <= word[13:0];
                    ADDR_CAL:  cal_q  <= word[13:0];
                    ADDR_TEST: test_q <= word[13:0];
                    default: ;                                  // Unaddressed
                endcase
            end
            // A high byte with no low byte before it is dropped
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion and calibration engine, timed by master clock
    eng_state_t state_q;
    logic [15:0] tick_q;            // Master clock periods remaining
    logic        busy_q;            // Busy output register
    logic        resultPush;        // Result ready to buffer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            tick_q  <= 16'h0000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (calReq) begin
                        state_q <= ST_CAL;                          // see R12
                        tick_q  <= 16'(CAL_LEN);
                    end else if (trigFall) begin
                        state_q <= ST_CONV;                         // see R11
                        tick_q  <= 16'(CONV_LEN);
                    end
                end
                ST_CONV, ST_CAL: begin
                    // A conversion stalls at the end if the buffer is full; calibration never stalls
                    if (tick_q != 16'h0000 && mclkTick) begin
                        tick_q <= tick_q - 16'h0001;                // see R10
                    end else if (tick_q == 16'h0000
                                 && (state_q == ST_CAL || resultPush)) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // Busy follows the engine; rises the cycle after the trigger fall
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_q != ST_IDLE) || calReq || trigFall;   // see R11, R12
        end
    end
    assign busy = busy_q;

    ////////////////////////////////////////////////////////////////////////
    // Result buffer
    sample_t inSample;
    sample_t outSample;
    logic    bufReady;
    logic    bufValid;
    logic    fifoFull_q;
    logic    rdHiPend_q;   // Low byte of a split calibration read taken
    // Coding: offset binary flipped to twos complement in bipolar mode
    assign inSample.bipolar = ctrl_q[CTRL_BIPOLAR];
    assign inSample.code    = ctrl_q[CTRL_BIPOLAR]
                              ? {~sampleCode[DATA_W-1], sampleCode[DATA_W-2:0]}
                              : sampleCode;                         // see R9
    assign resultPush = (state_q == ST_CONV) && (tick_q == 16'h0000) && bufReady;
    sample_fifo #(.WIDTH($bits(sample_t)), .DEPTH(DEPTH)) u_fifo (
        .clk      (clk),
        .srst     (srst),
        .inData   (inSample),
        .inValid  ((state_q == ST_CONV) && (tick_q == 16'h0000)),
        .inReady  (bufReady),
        .outData  (outSample),
        .outValid (bufValid),
        .outReady (rdEnd && (ctrl_q[CTRL_RDSEL+:2] == RSEL_DATA)
                   && (upper_byte_select || !rdHiPend_q))
    );
    always_ff @(posedge clk) begin
        if (srst) begin
            fifoFull_q <= 1'b0;
        end else begin
            fifoFull_q <= !bufReady;
        end
    end
    assign fifoFull = fifoFull_q;

    ////////////////////////////////////////////////////////////////////////
    // Read data path
    logic [DATA_W-1:0] selWord;     // Register picked by read select
    logic [LOW_PINS-1:0] bidirOut_q;
    logic [LOW_PINS-1:0] bidirOe_q;
    logic [UP_PINS-1:0]  upOut_q;
    logic [UP_PINS-1:0]  upOe_q;
    always_comb begin
        unique case (ctrl_q[CTRL_RDSEL+:2])
            RSEL_DATA: selWord = bufValid ? outSample.code : 12'h000;
            RSEL_CTRL: selWord = ctrl_q[DATA_W-1:0];
            RSEL_CAL:  selWord = cal_q[DATA_W-1:0];
            default:   selWord = test_q[DATA_W-1:0];
        endcase
    end
    // Track split reads; only calibration reads come in two halves, so a
    // twelve line result read must not block the next result from popping
    always_ff @(posedge clk) begin
        if (srst) begin
            rdHiPend_q <= 1'b0;
        end else if (rdEnd) begin
            rdHiPend_q <= !upper_byte_select
                          && (ctrl_q[CTRL_RDSEL+:2] == RSEL_CAL);  // see R5, R16
        end
    end
    // Pin drive registered one cycle behind the strobes
    always_ff @(posedge clk) begin
        if (srst) begin
            bidirOut_q <= 9'h000;
            bidirOe_q  <= 9'h000;
            upOut_q    <= 3'h0;
            upOe_q     <= 3'h0;
        end else if (rdActive) begin
            if (upper_byte_select) begin
                // Upper nibble on low lines, rest zero
                bidirOut_q <= {5'h00, selWord[DATA_W-1:BYTE_W]};    // see R2
                upOut_q    <= 3'h0;
                bidirOe_q  <= 9'h1FF;                               // see R7, R17
                upOe_q     <= 3'h0;                                 // see R8, R18
            end else begin
                bidirOut_q <= selWord[LOW_PINS-1:0];                // see R4
                upOut_q    <= selWord[DATA_W-1:LOW_PINS];
                bidirOe_q  <= 9'h1FF;                               // see R7, R17
                upOe_q     <= 3'h7;                                 // see R8
            end
        end else begin
            bidirOut_q <= 9'h000;
            bidirOe_q  <= 9'h000;                                   // see R17
            upOut_q    <= 3'h0;
            upOe_q     <= 3'h0;
        end
    end
    assign data_bus_bidir_out = bidirOut_q;
    assign data_bus_bidir_oe  = bidirOe_q;
    assign data_bus_upper_out = upOut_q;
    assign data_bus_upper_oe  = upOe_q;
endmodule

// file: adc_port_checker.sv
// Concurrent checks of the host port pins and busy sequencing
`timescale 1ns/1ns
module adc_port_checker
    import adc_port_pkg::*;
#(
    parameter int CONV_LEN   = CONV_CYCLES,  // Conversion length in master clocks
    parameter int CAL_LEN    = CAL_CYCLES,   // Calibration length in master clocks
    parameter int MCLK_RATIO = 63            // System clocks per master clock, rounded up
) (
    input wire logic                clk,
    input wire logic                srst,
    input wire logic                chipSelN,
    input wire logic                readN,
    input wire logic                writeN,
    input wire logic                upper_byte_select,
    input wire logic                convert_trigger,
    input wire logic [LOW_PINS-1:0] data_bus_bidir_out,
    input wire logic [LOW_PINS-1:0] data_bus_bidir_oe,
    input wire logic [UP_PINS-1:0]  data_bus_upper_oe,
    input wire logic                busy,
    input wire logic                fifoFull
);
    // Longest busy stretch, slack covers master clock phase
    localparam int LONGEST  = (CAL_LEN > CONV_LEN) ? CAL_LEN : CONV_LEN;
    localparam int BUSY_MAX = (LONGEST + 2) * MCLK_RATIO + 20;
    logic readReq;  // Selected read on the pins
    int   busyCnt;  // Cycles busy has stood
    assign readReq = !chipSelN && !readN;
    // Busy run length; a full buffer stalls legally, so the count restarts
    always_ff @(posedge clk) begin
        if (srst || !busy || fifoFull) begin
            busyCnt <= 0;
        end else begin
            busyCnt <= busyCnt + 1;
        end
    end
    // Both halves of the bus released
    function automatic logic dataOff();
        return data_bus_bidir_oe == 9'h000 && data_bus_upper_oe == 3'h0;
    endfunction
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    idle_no_drive_a: assert property (chipSelN |=> dataOff())
        else $error("Bus driven while not selected");
    drive_cause_a: assert property (data_bus_bidir_oe != 9'h000 |-> $past(readReq))
        else $error("Bus driven without a selected read");
    wide_read_a: assert property (readReq && !upper_byte_select |=>
        data_bus_bidir_oe == 9'h1FF && data_bus_upper_oe == 3'h7)
        else $error("Twelve line read not driven");
    high_read_a: assert property (readReq && upper_byte_select |=>
        data_bus_upper_oe == 3'h0 && data_bus_bidir_out[8:4] == 5'h00)
        else $error("High byte read lines wrong");
    write_no_drive_a: assert property (!chipSelN && !writeN |=> dataOff())
        else $error("Bus driven during a write");
    busy_start_a: assert property (!busy && !fifoFull && $fell(convert_trigger) |=> busy)
        else $error("Busy missed a trigger");
    busy_hold_a: assert property ($rose(busy) |-> busy [*8])
        else $error("Busy pulse too short");
    busy_bound_a: assert property (busyCnt <= BUSY_MAX)
        else $error("Busy stands too long");
endmodule
bind adc_byte_parallel_host_port adc_port_checker #(.CONV_LEN(CONV_LEN), .CAL_LEN(CAL_LEN))
    chk_i (.clk, .srst, .chipSelN, .readN, .writeN, .upper_byte_select, .convert_trigger,
    .data_bus_bidir_out, .data_bus_bidir_oe, .data_bus_upper_oe, .busy, .fifoFull);

// file: host_bus_model.sv
// Host bus master model with board-level wire resolution
`timescale 1ns/1ns
module host_bus_model (
    input  wire logic       clk,
    input  wire logic [8:0] devOut,
    input  wire logic [8:0] devOe,
    input  wire logic [2:0] devUpOut,
    input  wire logic [2:0] devUpOe,
    output logic            chipSelN,
    output logic            readN,
    output logic            writeN,
    output logic            upper_byte_select,
    output logic [8:0]      busLow,
    output logic [2:0]      busUp
);
    logic [8:0] hostDq   = 9'h000;  // Host write value
    logic       hostEn   = 1'b0;    // Host drives lines 0..8
    logic [8:0] floatPat = 9'h155;  // Undriven lines wander, no stale value
    initial begin
        chipSelN = 1'b1;
        readN = 1'b1;
        writeN = 1'b1;
        upper_byte_select = 1'b0;
    end
    always @(posedge clk) floatPat <= ~floatPat;
    // Lines 0..8 float; lines 9..11 pulled high on the board
    assign busLow = (devOe & devOut) | (~devOe & (hostEn ? hostDq : floatPat));
    assign busUp  = (devUpOe & devUpOut) | ~devUpOe;
    // One byte write; data held one edge past the strobe
    task automatic wr_byte(input logic sel, input logic upper, input logic [7:0] b);
        @(posedge clk);
        chipSelN <= ~sel;
        writeN <= 1'b0;
        upper_byte_select <= upper;
        hostDq <= {1'b0, b};
        hostEn <= 1'b1;
        @(posedge clk);
        chipSelN <= 1'b1;
        writeN <= 1'b1;
        @(posedge clk);
        hostEn <= 1'b0;
    endtask
    // Full register load, low byte first
    task automatic wr_word(input logic sel, input logic [15:0] w);
        wr_byte(sel, 1'b0, w[7:0]);
        wr_byte(sel, 1'b1, w[15:8]);
    endtask
    // One read; returns all twelve lines as the host sees them
    task automatic rd(input logic upper, output logic [11:0] v);
        @(posedge clk);
        chipSelN <= 1'b0;
        readN <= 1'b0;
        upper_byte_select <= upper;
        repeat (2) @(posedge clk);
        @(negedge clk);
        v = {busUp, busLow};
        @(posedge clk);
        chipSelN <= 1'b1;
        readN <= 1'b1;
        @(posedge clk);
    endtask
endmodule

// file: adc_byte_parallel_host_port_tb.sv
// Self-checking testbench of the byte-wide converter host port
`timescale 1ns/1ns
module adc_byte_parallel_host_port_tb;
    import adc_port_pkg::*;
    logic              clk = 1'b0;     // System clock, 250 MHz
    logic              mclk = 1'b0;    // Master clock, 4 MHz
    logic              srst = 1'b1;    // Synchronous reset
    logic              trig = 1'b1;    // Convert trigger, idle high
    logic [DATA_W-1:0] code = 12'h000; // Analog result presented
    logic              csN, rdN, wrN, ube, busy, fifoFull;
    logic [8:0]        busLow, dOut, dOe;
    logic [2:0]        busUp, uOut, uOe;
    logic [11:0]       v;              // Last host read
    int                badCount = 0;
    int                numChecks = 0;
    int                cycles = 0;
    int                mclkDiv = 0;    // Master clock half period counter
    always #2 clk = ~clk;
    // Master clock of 62 system periods (about 4 MHz); stepping it on the clock
    // edge keeps it from racing the design's sampling of the pin
    always @(posedge clk) begin
        if (mclkDiv == 30) begin
            mclkDiv <= 0;
            mclk    <= ~mclk;
        end else begin
            mclkDiv <= mclkDiv + 1;
        end
    end
    // Short counts keep the run brief
    adc_byte_parallel_host_port #(.CONV_LEN(2), .CAL_LEN(8)) dut (.clk(clk), .srst(srst),
        .chipSelN(csN), .readN(rdN), .writeN(wrN), .upper_byte_select(ube),
        .master_clock_in(mclk), .convert_trigger(trig), .sampleCode(code),
        .data_bus_bidir_in(busLow), .data_bus_bidir_out(dOut), .data_bus_bidir_oe(dOe),
        .data_bus_upper_out(uOut), .data_bus_upper_oe(uOe), .busy(busy), .fifoFull(fifoFull));
    host_bus_model host (.clk(clk), .devOut(dOut), .devOe(dOe), .devUpOut(uOut),
        .devUpOe(uOe), .chipSelN(csN), .readN(rdN), .writeN(wrN), .upper_byte_select(ube),
        .busLow(busLow), .busUp(busUp));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        numChecks++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Bounded wait for busy, sampled between edges
    task automatic wait_busy(input logic val, input int lim, output int n);
        n = 0;
        @(negedge clk);
        while (busy !== val && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk({11'h000, busy}, {11'h000, val});
    endtask
    task automatic conv(input logic [11:0] c);
        int n;
        @(posedge clk);
        code <= c;
        trig <= 1'b0;
        @(posedge clk);
        trig <= 1'b1;
        wait_busy(1'b1, 4, n);
        wait_busy(1'b0, 400, n);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_fifo();
        for (int i = 0; i < FIFO_DEPTH; i++) conv(12'(i * 129));
        chk({11'h000, fifoFull}, 12'h001);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            host.rd(1'b0, v);
            chk(v, 12'(i * 129));
        end
        host.rd(1'b0, v);
        chk(v, 12'h000);
        @(negedge clk);
        chk({11'h000, fifoFull}, 12'h000);
    endtask
    task automatic s_bipolar();
        host.wr_word(1'b1, 16'hC001);
        conv(12'h123);
        host.rd(1'b1, v);
        chk(v, 12'hE09);
        host.wr_word(1'b0, 16'hC000);
        conv(12'h123);
        host.rd(1'b0, v);
        chk(v, 12'h923);
    endtask
    task automatic s_ctrl_read();
        host.wr_word(1'b1, 16'hC041);
        host.rd(1'b0, v);
        chk(v, 12'h041);
        host.wr_word(1'b1, 16'h0000);
        host.rd(1'b0, v);
        chk(v, 12'h041);
        // Calibration register back in two reads, low byte first
        host.wr_word(1'b1, 16'h8ABC);
        host.wr_word(1'b1, 16'hC080);
        host.rd(1'b0, v);
        chk(v, 12'hABC);
        host.rd(1'b1, v);
        chk(v, 12'hE0A);
        // Test register through the twelve line read
        host.wr_word(1'b1, 16'h4123);
        host.wr_word(1'b1, 16'hC0C0);
        host.rd(1'b0, v);
        chk(v, 12'h123);
    endtask
    task automatic s_cal();
        int n;
        host.wr_word(1'b1, 16'hC002);
        wait_busy(1'b1, 20, n);
        wait_busy(1'b0, 1000, n);
        chk(12'(n >= 430), 12'h001);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            badCount++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk({dOe, uOe}, 12'h000);
        chk({11'h000, busy}, 12'h000);
        s_fifo();
        s_bipolar();
        s_ctrl_read();
        s_cal();
        summarize();
    end
endmodule
